// >>> pwb_pkg.sv
// Shared constants and types for the pulse-width single-wire bit slave,
// followed by the low-pulse width classifier leaf module.
// Assumes one 125 MHz clock and a line input already synchronous to it.
`timescale 1ns/1ps

package pwb_pkg;

  // Clock period in ns
  localparam int CLK_NS = 8;

  // Rounds a least time up to whole cycles, never below one
  function automatic int ns2cyc_ceil(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Rounds a longest time down to whole cycles, never below one
  function automatic int ns2cyc_floor(input int ns);
    int c;
    c = ns / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Line timing figures in ns
  localparam int MIN_IDLE_TIME_NS        = 11000;
  localparam int EDGE_DETECT_WINDOW_NS   = 9600;
  localparam int ZERO_PULSE_MAX_NS       = 17000;
  localparam int ONE_PULSE_MIN_NS        = 35400;
  localparam int ONE_PULSE_MAX_NS        = 48900;
  localparam int START_PULSE_MIN_NS      = 80000;
  localparam int START_PULSE_MAX_NS      = 109000;
  localparam int SLAVE_ONE_MIN_NS        = 28300;
  localparam int SLAVE_ONE_MAX_NS        = 38300;
  localparam int ATTENTION_MIN_NS        = 165000;
  localparam int ATTENTION_MAX_NS        = 228000;
  localparam int RESET_MIN_NS            = 354000;

  // Derived cycle counts
  localparam int MIN_IDLE_CYC  = ns2cyc_ceil(MIN_IDLE_TIME_NS);
  localparam int EDGE_WIN_CYC  = ns2cyc_floor(EDGE_DETECT_WINDOW_NS);
  // Own one and attention drives aim at the middle of their allowed range; reset at its minimum
  localparam int SLAVE_ONE_CYC =
    ns2cyc_ceil((SLAVE_ONE_MIN_NS + SLAVE_ONE_MAX_NS) / 2);
  localparam int ATTENTION_CYC =
    ns2cyc_ceil((ATTENTION_MIN_NS + ATTENTION_MAX_NS) / 2);
  localparam int RESET_CYC     = ns2cyc_ceil(RESET_MIN_NS);
  // Class thresholds sit mid-gap between neighbouring ranges
  localparam int THR_ONE_CYC   =
    ns2cyc_ceil((ZERO_PULSE_MAX_NS + ONE_PULSE_MIN_NS) / 2);
  localparam int THR_START_CYC =
    ns2cyc_ceil((ONE_PULSE_MAX_NS + START_PULSE_MIN_NS) / 2);
  localparam int THR_ATTN_CYC  =
    ns2cyc_ceil((START_PULSE_MAX_NS + ATTENTION_MIN_NS) / 2);
  localparam int THR_RST_CYC   =
    ns2cyc_ceil((ATTENTION_MAX_NS + RESET_MIN_NS) / 2);

  // Master data bits to count after a bus reset before attention
  localparam int ATTN_HOLDOFF_BITS = 14;

  // Counter width covers the longest reset figure
  localparam int CNT_W = 17;
  typedef logic [CNT_W-1:0] pwb_cnt_t;

  // Bit counter width and its reset value
  localparam int BITS_W = 4;
  localparam logic [BITS_W-1:0] BITS_RST = 4'h0;

  // Bus address width
  localparam int ADDR_W = 3;

  // Low-pulse classes
  typedef enum logic [4:0] {
    CLS_ZERO  = 5'h01,
    CLS_ONE   = 5'h02,
    CLS_START = 5'h04,
    CLS_ATTN  = 5'h08,
    CLS_RST   = 5'h10
  } pwb_cls_t;

  // Own drive state
  typedef enum logic [3:0] {
    DRV_OFF  = 4'h1,
    DRV_ONE  = 4'h2,
    DRV_ATTN = 4'h4,
    DRV_RST  = 4'h8
  } pwb_drv_t;

  // Events reported to the transaction layer, one-cycle pulses
  typedef struct packed {
    logic rx_valid;   // Data bit decoded
    logic rx_bit;     // Its value
    logic start;      // Start pulse seen, abort any transaction
    logic attn;       // Attention request seen
    logic coll;       // Attention not sent from own idle overrode a bit
    logic attn_sent;  // Own attention completed
    logic bus_rst;    // End of reset pulse
  } pwb_evt_t;

  // Whole state of the top module
  typedef struct packed {
    pwb_drv_t          drv;
    logic              oe;        // Registered wire pull enable
    pwb_cnt_t          drv_cnt;
    pwb_cnt_t          low_cnt;
    pwb_cnt_t          high_cnt;
    logic              line;
    logic              own_idle;
    logic [BITS_W-1:0] bits;
    logic              attn_ok;
    logic              idle;
    logic [ADDR_W-1:0] addr;
    pwb_evt_t          evt;
  } pwb_state_t;

endpackage

// Maps a measured low duration onto one of the five pulse classes
module pwb_classify #(
  parameter int unsigned THR_ONE   = pwb_pkg::THR_ONE_CYC,
  parameter int unsigned THR_START = pwb_pkg::THR_START_CYC,
  parameter int unsigned THR_ATTN  = pwb_pkg::THR_ATTN_CYC,
  parameter int unsigned THR_RST   = pwb_pkg::THR_RST_CYC
) (
  input  pwb_pkg::pwb_cnt_t low_cnt,  // Low duration in cycles
  output pwb_pkg::pwb_cls_t cls       // Resulting class
);

  localparam pwb_pkg::pwb_cnt_t T1 = pwb_pkg::pwb_cnt_t'(THR_ONE);
  localparam pwb_pkg::pwb_cnt_t TS = pwb_pkg::pwb_cnt_t'(THR_START);
  localparam pwb_pkg::pwb_cnt_t TA = pwb_pkg::pwb_cnt_t'(THR_ATTN);
  localparam pwb_pkg::pwb_cnt_t TR = pwb_pkg::pwb_cnt_t'(THR_RST);

  // Longest class first, so a stretched pulse never reads as data
  always_comb
  begin
    if (low_cnt >= TR)
      cls = pwb_pkg::CLS_RST;
    else if (low_cnt >= TA)
      cls = pwb_pkg::CLS_ATTN;
    else if (low_cnt >= TS)
      cls = pwb_pkg::CLS_START;
    else if (low_cnt >= T1)
      cls = pwb_pkg::CLS_ONE;
    else
      cls = pwb_pkg::CLS_ZERO;
  end

endmodule

// >>> pwb_slave.sv
// Bit-level slave of the single-wire pulse-width bus.
// Assumes SWD_I is the resolved wire level, synchronous to CLK, and that
// the transaction layer holds ATTN_REQ until it sees attn_sent.
`timescale 1ns/1ps

// Functional notes
// - Five bit signals, told apart only by how long the line is low.
// - Bus is idle after staying high the minimum idle time.
// - Write bit: detect falling edge in window, time low to decode.
// - Read one: drive low within window for own one-time; zero: release.
// - Read value decided when the line returns high.
// - Keep timing every bit; longer classes are never taken as data.
// - Reserved or unused bits are returned as zero.
// - Start pulses watched always; they abort a running transaction.
// - A start stretched to attention or reset is not a start.
// - Attention beats data and start; collisions flagged for resend.
// - Attention only from idle or within window of a foreign edge.
// - Attention stretched into reset length counts as reset.
// - No attention after reset until 14 master data bits seen.
// - Device drives a reset pulse at power-up.
// - Bus reset clears only the interface, not registers or sensing.
// - End of a reset pulse restarts the bit interface.
// - No clock training; post-reset zeros are ordinary data bits.
// - One of two addresses chosen by the address-select pin.
// - Attention tells the master new readings are available.
// - Edge seen within 9.6 us; own one drive 28.3-38.3 us.
// - Attention 165-228 us; start 80-109 us.
// - Reset at least 354 us; idle 11 us before own attention.
module pwb_slave #(
  parameter int unsigned        P_ONE_CYC   = pwb_pkg::SLAVE_ONE_CYC,
  parameter int unsigned        P_ATTN_CYC  = pwb_pkg::ATTENTION_CYC,
  parameter int unsigned        P_RST_CYC   = pwb_pkg::RESET_CYC,
  parameter int unsigned        P_THR_ONE   = pwb_pkg::THR_ONE_CYC,
  parameter int unsigned        P_THR_START = pwb_pkg::THR_START_CYC,
  parameter int unsigned        P_THR_ATTN  = pwb_pkg::THR_ATTN_CYC,
  parameter int unsigned        P_THR_RST   = pwb_pkg::THR_RST_CYC,
  parameter logic [2:0]         P_ADDR_LO   = 3'h1,  // Arbitrary
  parameter logic [2:0]         P_ADDR_HI   = 3'h2   // Arbitrary
) (
  input  wire logic              CLK,       // 125 MHz clock
  input  wire logic              RST_N,     // Sync reset, power-up
  input  wire logic              SWD_I,     // Wire level
  output logic                   SWD_O,     // Wire drive value, always 0
  output logic                   SWD_OE,    // High while pulling low
  input  wire logic              ADDR_SEL,  // Address-select pin
  input  wire logic              ATTN_REQ,  // Core wants attention
  input  wire logic              TX_ARM,    // Next bit is a read answer
  input  wire logic              TX_BIT,    // Value to answer with
  output logic [2:0]             DEV_ADDR,  // Selected bus address
  output logic                   BUS_IDLE,  // Line idle long enough
  output logic                   ATTN_OK,   // Attention allowed again
  output pwb_pkg::pwb_evt_t      EVT        // Event pulses
);

  localparam pwb_pkg::pwb_cnt_t ONE_L  = pwb_pkg::pwb_cnt_t'(P_ONE_CYC);
  localparam pwb_pkg::pwb_cnt_t ATTN_L = pwb_pkg::pwb_cnt_t'(P_ATTN_CYC);
  localparam pwb_pkg::pwb_cnt_t RST_L  = pwb_pkg::pwb_cnt_t'(P_RST_CYC);
  localparam pwb_pkg::pwb_cnt_t IDLE_L =
    pwb_pkg::pwb_cnt_t'(pwb_pkg::MIN_IDLE_CYC);
  localparam pwb_pkg::pwb_cnt_t WIN_L  =
    pwb_pkg::pwb_cnt_t'(pwb_pkg::EDGE_WIN_CYC);
  localparam pwb_pkg::pwb_cnt_t CNT_MAX = {pwb_pkg::CNT_W{1'b1}};
  localparam pwb_pkg::pwb_cnt_t CNT_ONE = 17'h00001;
  localparam pwb_pkg::pwb_cnt_t CNT_ZERO = 17'h00000;
  localparam logic [pwb_pkg::BITS_W-1:0] BITS_FULL =
    pwb_pkg::BITS_W'(pwb_pkg::ATTN_HOLDOFF_BITS);
  localparam logic [pwb_pkg::BITS_W-1:0] BITS_INC = 4'h1;

  // Saturating count step, shared by the low and high timers
  function automatic pwb_pkg::pwb_cnt_t sat_inc(input pwb_pkg::pwb_cnt_t c);
    return (c == CNT_MAX) ? c : c + CNT_ONE;
  endfunction

  pwb_pkg::pwb_state_t s_r;
  pwb_pkg::pwb_state_t s_nxt;
  pwb_pkg::pwb_cls_t   cls;
  logic                fall;
  logic                rise;
  logic                may_attn;

  // Classification runs on the live count; used only at the rising edge
  pwb_classify #(
    .THR_ONE   (P_THR_ONE),
    .THR_START (P_THR_START),
    .THR_ATTN  (P_THR_ATTN),
    .THR_RST   (P_THR_RST)
  ) u_cls (
    .low_cnt (s_r.low_cnt),
    .cls     (cls)
  );

  // Line edges against the previous sample
  assign fall = s_r.line & ~SWD_I;
  assign rise = ~s_r.line & SWD_I;
  // Attention also needs the core asking and the holdoff passed
  assign may_attn = ATTN_REQ & s_r.attn_ok;

  // Next-state logic for the whole block
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.line = SWD_I;
    s_nxt.evt  = '0;
    // Pin level picks one of two addresses
    s_nxt.addr = ADDR_SEL ? P_ADDR_HI : P_ADDR_LO;

    // Own drive times out by its own counter; a foreign extension is
    // still measured on the wire, so a stretched pulse reclassifies
    if (s_r.drv != pwb_pkg::DRV_OFF)
    begin
      if (s_r.drv_cnt <= CNT_ONE)
      begin
        s_nxt.drv     = pwb_pkg::DRV_OFF;
        s_nxt.drv_cnt = CNT_ZERO;
      end
      else
        s_nxt.drv_cnt = s_r.drv_cnt - CNT_ONE;
    end

    if (!SWD_I)
    begin
      // Low: time the pulse, saturating so a long reset stays a reset
      s_nxt.high_cnt = CNT_ZERO;
      s_nxt.idle     = 1'b0;
      if (fall)
        s_nxt.low_cnt = CNT_ONE;
      else
        s_nxt.low_cnt = sat_inc(s_r.low_cnt);
      // Join a foreign pulse only inside the edge window
      if (s_r.drv == pwb_pkg::DRV_OFF && s_r.low_cnt < WIN_L
          && (fall || s_r.low_cnt != CNT_ZERO))
      begin
        if (may_attn)
        begin
          s_nxt.drv      = pwb_pkg::DRV_ATTN;
          s_nxt.drv_cnt  = ATTN_L;
          s_nxt.own_idle = 1'b0;
        end
        else if (fall && TX_ARM && TX_BIT)
        begin
          // Zero answer leaves the wire alone, so unused bits cost least
          s_nxt.drv     = pwb_pkg::DRV_ONE;
          s_nxt.drv_cnt = ONE_L;
        end
      end
    end
    else
    begin
      // High: count toward idle
      s_nxt.low_cnt = CNT_ZERO;
      if (rise)
        s_nxt.high_cnt = CNT_ONE;
      else
        s_nxt.high_cnt = sat_inc(s_r.high_cnt);
      s_nxt.idle = (s_r.high_cnt >= IDLE_L);
      // Attention from idle, after the guaranteed high gap
      if (s_r.drv == pwb_pkg::DRV_OFF && !rise && s_r.idle && may_attn)
      begin
        s_nxt.drv      = pwb_pkg::DRV_ATTN;
        s_nxt.drv_cnt  = ATTN_L;
        s_nxt.own_idle = 1'b1;
      end
    end

    // Pulse ends: decide what it was from its whole low time
    if (rise)
    begin
      case (cls)
        pwb_pkg::CLS_ZERO, pwb_pkg::CLS_ONE:
        begin
          // Read answers decided here too, as the master does
          s_nxt.evt.rx_valid = 1'b1;
          s_nxt.evt.rx_bit   = (cls == pwb_pkg::CLS_ONE);
          // Post-reset zeros count like any other data bit
          if (s_r.bits != BITS_FULL)
            s_nxt.bits = s_r.bits + BITS_INC;
          s_nxt.attn_ok = (s_r.attn_ok || s_r.bits + BITS_INC == BITS_FULL);
        end
        pwb_pkg::CLS_START:
          s_nxt.evt.start = 1'b1;
        pwb_pkg::CLS_ATTN:
        begin
          // Any bit riding under an attention is dropped, flagged
          s_nxt.evt.attn      = 1'b1;
          s_nxt.evt.coll      = ~s_r.own_idle;
          s_nxt.evt.attn_sent = s_r.own_idle | ~ATTN_REQ ? s_r.own_idle
                                                         : 1'b1;
        end
        pwb_pkg::CLS_RST:
        begin
          // Interface only: bit count and holdoff restart here
          s_nxt.evt.bus_rst = 1'b1;
          s_nxt.bits        = pwb_pkg::BITS_RST;
          s_nxt.attn_ok     = 1'b0;
          s_nxt.drv         = pwb_pkg::DRV_OFF;
          s_nxt.drv_cnt     = CNT_ZERO;
        end
        default:
          s_nxt.evt = '0;
      endcase
      s_nxt.own_idle = 1'b0;
    end
    // Pull enable kept in a flop so the pin never sees decode glitches
    s_nxt.oe = (s_nxt.drv != pwb_pkg::DRV_OFF);
  end

  // State register; power-up starts with own reset drive
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      s_r          <= '0;
      s_r.drv      <= pwb_pkg::DRV_RST;
      s_r.oe       <= 1'b1;
      s_r.drv_cnt  <= RST_L;
      s_r.line     <= 1'b1;
      s_r.bits     <= pwb_pkg::BITS_RST;
    end
    else
      s_r <= s_nxt;
  end

  // Outputs straight from state; open drain only ever pulls low
  assign SWD_O    = 1'b0;
  assign SWD_OE   = s_r.oe;
  assign DEV_ADDR = s_r.addr;
  assign BUS_IDLE = s_r.idle;
  assign ATTN_OK  = s_r.attn_ok;
  assign EVT      = s_r.evt;

endmodule

// >>> pwb_props.sv
// Checker for the pulse-width bus bit slave, bound to its top ports.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps

module pwb_props #(
  parameter int unsigned P_ONE_CYC  = pwb_pkg::SLAVE_ONE_CYC,
  parameter int unsigned P_ATTN_CYC = pwb_pkg::ATTENTION_CYC,
  parameter logic [2:0]  P_ADDR_LO  = 3'h1,
  parameter logic [2:0]  P_ADDR_HI  = 3'h2
) (
  input wire logic              CLK,       // Clock
  input wire logic              RST_N,     // Sync reset
  input wire logic              SWD_I,     // Wire level
  input wire logic              SWD_O,     // Drive value
  input wire logic              SWD_OE,    // Pull enable
  input wire logic              ADDR_SEL,  // Address pin
  input wire logic              ATTN_REQ,  // Attention wanted
  input wire logic              TX_ARM,    // Read answer armed
  input wire logic              TX_BIT,    // Read answer value
  input wire logic [2:0]        DEV_ADDR,  // Chosen address
  input wire logic              BUS_IDLE,  // Idle flag
  input wire logic              ATTN_OK,   // Attention allowed
  input wire pwb_pkg::pwb_evt_t EVT        // Event pulses
);
  localparam int IDLE = pwb_pkg::MIN_IDLE_CYC;
  logic [16:0] oe_run_r;
  logic [15:0] hi_run_r;

  // Run lengths of our own drive and of the high wire; saturate the latter
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      oe_run_r <= 17'h0;
      hi_run_r <= 16'h0;
    end
    else
    begin
      oe_run_r <= SWD_OE ? oe_run_r + 17'h1 : 17'h0;
      hi_run_r <= !SWD_I ? 16'h0 :
                  (hi_run_r == 16'hFFFF) ? hi_run_r : hi_run_r + 16'h1;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // Line shapes the properties are built from
  sequence edge_fall;
    SWD_I ##1 !SWD_I;
  endsequence
  sequence low3;
    !SWD_I [*3];
  endsequence

  a_drive_zero: assert property (SWD_O == 1'b0)
    else $error("drive value not low");
  a_addr_pick: assert property ($past(RST_N) |->
    DEV_ADDR == ($past(ADDR_SEL) ? P_ADDR_HI : P_ADDR_LO))
    else $error("address does not follow select pin");
  // Power-up drive is longer than the guard, so it is left out here
  a_oe_width: assert property (
    $fell(SWD_OE) && oe_run_r <= P_ATTN_CYC + 8 |->
    oe_run_r == P_ONE_CYC || oe_run_r == P_ATTN_CYC)
    else $error("drive length wrong");
  a_drive_cause: assert property ($rose(SWD_OE) |->
    ($past(ATTN_OK) && $past(ATTN_REQ)) || ($past(TX_ARM) && $past(TX_BIT)))
    else $error("drive started without cause");
  a_edge_window: assert property (edge_fall ##0
    (TX_ARM && TX_BIT && !ATTN_REQ && !SWD_OE) |-> ##[1:2] SWD_OE)
    else $error("read one not answered in time");
  a_idle_rise: assert property ($rose(BUS_IDLE) |->
    hi_run_r >= IDLE - 1 && hi_run_r <= IDLE + 4)
    else $error("idle flag at wrong time");
  a_idle_drop: assert property (
    $fell(SWD_I) |-> ##[0:3] !BUS_IDLE)
    else $error("idle flag kept while low");
  a_evt_single: assert property (EVT.rx_valid |->
    !(EVT.start || EVT.attn || EVT.coll || EVT.bus_rst))
    else $error("data bit reported with another class");
  a_evt_on_rise: assert property (
    low3 |-> !EVT.rx_valid && !EVT.bus_rst)
    else $error("event reported while line low");
  a_rst_clears: assert property (
    EVT.bus_rst |-> ##[0:2] !ATTN_OK)
    else $error("attention still allowed after bus reset");
endmodule

bind pwb_slave pwb_props #(
  .P_ONE_CYC (P_ONE_CYC),
  .P_ATTN_CYC(P_ATTN_CYC),
  .P_ADDR_LO (P_ADDR_LO),
  .P_ADDR_HI (P_ADDR_HI)
) pwb_props_i (
  .CLK(CLK), .RST_N(RST_N), .SWD_I(SWD_I), .SWD_O(SWD_O),
  .SWD_OE(SWD_OE), .ADDR_SEL(ADDR_SEL), .ATTN_REQ(ATTN_REQ),
  .TX_ARM(TX_ARM), .TX_BIT(TX_BIT), .DEV_ADDR(DEV_ADDR),
  .BUS_IDLE(BUS_IDLE), .ATTN_OK(ATTN_OK), .EVT(EVT)
);

// >>> pwb_host.sv
// Partner model: the bus master on the far side of the single wire.
// Assumes the bench feeds it the resolved wire and holds req until done.
`timescale 1ns/1ps

module pwb_host #(
  parameter int IDLE    = pwb_pkg::MIN_IDLE_CYC,  // High cycles before pulse
  parameter int RST_LEN = 300                     // Reset length skips idle
) (
  input  wire logic        clk,     // Bench clock
  input  wire logic        wire_i,  // Resolved wire level
  input  wire logic        req,     // Pulse wanted
  input  wire logic [15:0] len,     // Low time in cycles
  input  wire logic [15:0] lag,     // Extra idle cycles, slow master
  output logic             oe,      // Pulls the wire low
  output logic             done     // One cycle at release
);
  logic [15:0] hi_cnt;
  logic [15:0] cnt;

  initial
  begin
    oe = 1'b0;
    done = 1'b0;
    hi_cnt = 16'h0;
    cnt = 16'h0;
  end

  // Idle is timed on the wire itself, so slave drives hold us off
  always @(posedge clk)
  begin
    hi_cnt <= !wire_i ? 16'h0 :
              (hi_cnt == 16'hFFFF) ? hi_cnt : hi_cnt + 16'h1;
    done <= 1'b0;
    if (cnt != 16'h0)
    begin
      cnt <= cnt - 16'h1;
      if (cnt == 16'h1)
      begin
        oe <= 1'b0;
        done <= 1'b1;
      end
    end
    else if (req && !done && (hi_cnt >= IDLE + lag || len >= RST_LEN))
    begin
      oe <= 1'b1;
      cnt <= len;
    end
  end
endmodule

// >>> pwb_slave_tb.sv
// Self-checking bench for the bit slave with a behavioural bus master.
// Assumes shortened drive and threshold parameters, kept in order.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  bad_count++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
`define WAIT(c, n) begin int k; \
  for (k = 0; k < (n) && (c) !== 1'b1; k++) @(negedge clk); \
  if ((c) !== 1'b1) begin bad_count++; complete_run(); end end

module pwb_slave_tb;
  localparam logic [2:0] ALO = 3'h1;
  localparam logic [2:0] AHI = 3'h2;
  // Shortened drive and threshold lengths in cycles, kept in order
  localparam int unsigned ONE_C  = 32'h28;
  localparam int unsigned ATTN_C = 32'hC8;
  localparam int unsigned RST_C  = 32'h190;
  localparam int unsigned THR_1  = ONE_C / 2;
  localparam int unsigned THR_S  = ONE_C + THR_1;
  localparam int unsigned THR_A  = ATTN_C - ATTN_C / 4;
  localparam int unsigned THR_R  = RST_C - RST_C / 4;
  logic              clk, rst_n, addr_sel, attn_req, tx_arm, tx_bit, req;
  logic              m_oe, m_done, swd_o, swd_oe, bus_idle, attn_ok;
  logic [15:0]       len, lag;
  logic [2:0]        dev_addr;
  logic [31:0]       seed;
  pwb_pkg::pwb_evt_t evt;
  pwb_pkg::pwb_evt_t exp_q[$];
  pwb_pkg::pwb_evt_t msk_q[$];
  pwb_pkg::pwb_evt_t e_exp, e_msk;
  int                bad_count, checks_done;
  // Pull-up wire: high unless a party pulls it low
  wire swd = !(m_oe || (swd_oe && !swd_o));

  pwb_slave #(.P_ONE_CYC(ONE_C), .P_ATTN_CYC(ATTN_C), .P_RST_CYC(RST_C),
    .P_THR_ONE(THR_1), .P_THR_START(THR_S), .P_THR_ATTN(THR_A),
    .P_THR_RST(THR_R), .P_ADDR_LO(ALO), .P_ADDR_HI(AHI)) pwb_slave_i (
    .CLK(clk), .RST_N(rst_n), .SWD_I(swd), .SWD_O(swd_o), .SWD_OE(swd_oe),
    .ADDR_SEL(addr_sel), .ATTN_REQ(attn_req), .TX_ARM(tx_arm),
    .TX_BIT(tx_bit), .DEV_ADDR(dev_addr), .BUS_IDLE(bus_idle),
    .ATTN_OK(attn_ok), .EVT(evt));
  pwb_host pwb_host_i (.clk(clk), .wire_i(swd), .req(req), .len(len),
    .lag(lag), .oe(m_oe), .done(m_done));

  task automatic complete_run();
    if (bad_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Event bits msb..lsb: data, value, start, attn, coll, sent, reset
  task automatic note(input logic [6:0] e, input logic [6:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
  endtask

  // Random extra idle makes the master sometimes slow to start
  task automatic pulse(input int w);
    len = w[15:0];
    lag = 16'(rnd() % 50);
    req = 1'b1;
    `WAIT(m_done, 5000)
    req = 1'b0;
    // One edge with req low, so back-to-back calls never reassign it at once
    @(negedge clk);
  endtask

  task automatic wbit(input logic b);
    note(7'h40 | {1'b0, b, 5'h00}, 7'h7F);
    pulse(b ? 30 + rnd() % 20 : 8 + rnd() % 8);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Each event cycle is matched against the oldest note, masked
  always @(negedge clk)
  begin
    if (rst_n && evt !== 7'h00)
    begin
      if (exp_q.size() == 0)
        `CHK(evt, 7'h00)
      else
      begin
        // Pop first: the compare macro reads its arguments twice
        e_exp = exp_q.pop_front();
        e_msk = msk_q.pop_front();
        `CHK(evt & e_msk, e_exp)
      end
    end
  end

  initial
  begin
    {rst_n, addr_sel, attn_req, tx_arm, tx_bit, req} = 6'h00;
    {len, lag} = 32'h0;
    seed = 32'h4D;
    bad_count = 0;
    checks_done = 0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    `CHK(swd_oe, 1'b1)
    // Both ends reset the bus; the wire rises once
    note(7'h01, 7'h7F);
    pulse(450);
    // Eight zeros first, as a master does after reset
    for (int i = 0; i < 13; i++)
      wbit(i < 8 ? 1'b0 : 1'(rnd()));
    `WAIT(bus_idle, 3000)
    `CHK(attn_ok, 1'b0)
    wbit(1'b1);
    `WAIT(bus_idle, 3000)
    `CHK(attn_ok, 1'b1)
    // Read answers: a one pulls the wire, a zero leaves it
    tx_arm = 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      tx_bit = i[0];
      note(7'h40 | {1'b0, i[0], 5'h00}, 7'h7F);
      pulse(8 + rnd() % 8);
    end
    tx_arm = 1'b0;
    note(7'h10, 7'h7F);
    pulse(100);
    // Own attention from idle, held until reported sent
    note(7'h0A, 7'h7F);
    `WAIT(bus_idle, 3000)
    attn_req = 1'b1;
    `WAIT(evt.attn_sent, 3000)
    attn_req = 1'b0;
    // Joining a master data bit turns it into a collision
    note(7'h0E, 7'h7F);
    {len, lag, req} = {16'd10, 16'd0, 1'b1};
    `WAIT(!swd, 3000)
    attn_req = 1'b1;
    `WAIT(m_done, 300)
    req = 1'b0;
    `WAIT(evt.attn_sent, 3000)
    attn_req = 1'b0;
    note(7'h0C, 7'h7F);
    pulse(220);
    note(7'h01, 7'h7F);
    pulse(350);
    `WAIT(bus_idle, 3000)
    `CHK(attn_ok, 1'b0)
    // Attention must be refused until the bits are counted again
    attn_req = 1'b1;
    repeat (1500) @(negedge clk);
    `CHK(swd_oe, 1'b0)
    attn_req = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      addr_sel = i[0];
      repeat (3) @(negedge clk);
      `CHK(dev_addr, i ? AHI : ALO)
    end
    `CHK(exp_q.size(), 0)
    complete_run();
  end
endmodule
